// ===== design/cbk_pkg.sv
`default_nettype none
package cbk_pkg;
   // ==========================================================
   // widths
   localparam int unsigned    DATA_W      = 8;
   localparam int unsigned    PC_W        = 13;
   localparam int unsigned    HOLD_W      = 5;
   localparam int unsigned    JUMP_W      = 11;
   // ==========================================================
   // register offsets within a bank
   localparam logic [6:0]     OFS_IND     = 7'h00;
   localparam logic [6:0]     OFS_T0CNT   = 7'h01;
   localparam logic [6:0]     OFS_PC_LO   = 7'h02;
   localparam logic [6:0]     OFS_STATUS  = 7'h03;
   localparam logic [6:0]     OFS_PTR     = 7'h04;
   localparam logic [6:0]     OFS_PIO_A   = 7'h05;
   localparam logic [6:0]     OFS_PIO_B   = 7'h06;
   localparam logic [6:0]     OFS_HOLD    = 7'h0a;
   localparam logic [6:0]     OFS_INTCTL  = 7'h0b;
   localparam logic [6:0]     OFS_PIRQ1   = 7'h0c;
   localparam logic [6:0]     OFS_PIRQ2   = 7'h0d;
   localparam logic [6:0]     OFS_T1LO    = 7'h0e;
   localparam logic [6:0]     OFS_T1HI    = 7'h0f;
   localparam logic [6:0]     OFS_T1CTL   = 7'h10;
   localparam logic [6:0]     OFS_T2CNT   = 7'h11;
   localparam logic [6:0]     OFS_T2CTL   = 7'h12;
   localparam logic [6:0]     OFS_SERBUF  = 7'h13;
   localparam logic [6:0]     OFS_SERCTL  = 7'h14;
   localparam logic [6:0]     OFS_CCLO    = 7'h15;
   localparam logic [6:0]     OFS_CCHI    = 7'h16;
   localparam logic [6:0]     OFS_CCCTL   = 7'h17;
   localparam logic [6:0]     OFS_CONV_HI = 7'h1e;
   localparam logic [6:0]     OFS_ADCTL0  = 7'h1f;
   localparam logic [6:0]     OFS_GPR_LO  = 7'h20;
   localparam logic [6:0]     OFS_GPR_COM = 7'h70;
   localparam int unsigned    GPR_DEPTH   = 96;
   // ==========================================================
   // reset values and implemented-bit masks
   localparam logic [7:0]     RST_ZERO    = 8'h00;
   localparam logic [7:0]     RST_STATUS  = 8'h18;
   localparam logic [12:0]    RST_PC      = 13'h0000;
   localparam logic [15:0]    RST_T1      = 16'h0000;
   localparam logic [15:0]    T1_MAX      = 16'hffff;
   localparam logic [7:0]     T0_MAX      = 8'hff;
   localparam logic [7:0]     MASK_ALL    = 8'hff;
   localparam logic [7:0]     MASK_HOLD   = 8'h1f;
   localparam logic [7:0]     MASK_PIRQ1  = 8'h4f;
   localparam logic [7:0]     MASK_PIRQ2  = 8'h88;
   localparam logic [7:0]     MASK_T1CTL  = 8'h3f;
   localparam logic [7:0]     MASK_T2CTL  = 8'h7f;
   localparam logic [7:0]     MASK_ST_SW  = 8'he7;
   // ==========================================================
   // field positions
   localparam int unsigned    ST_IRP      = 7;
   localparam int unsigned    ST_TO       = 4;
   localparam int unsigned    ST_PD       = 3;
   localparam int unsigned    IC_T0IF     = 2;
   localparam int unsigned    PIRQ1_T1OVF = 0;
   localparam int unsigned    T1CTL_ON    = 0;
   // ==========================================================
   // plain storage registers, built from one byte register each
   localparam int unsigned    GEN_N       = 15;
   localparam int unsigned    GI_PTR      = 0;
   localparam int unsigned    GI_PA       = 1;
   localparam int unsigned    GI_PB       = 2;
   localparam int unsigned    GI_HOLD     = 3;
   localparam int unsigned    GI_T1CTL    = 5;
   localparam logic [6:0]     GEN_OFS [GEN_N] = '{OFS_PTR, OFS_PIO_A,
      OFS_PIO_B, OFS_HOLD, OFS_PIRQ2, OFS_T1CTL, OFS_T2CNT, OFS_T2CTL,
      OFS_SERBUF, OFS_SERCTL, OFS_CCLO, OFS_CCHI, OFS_CCCTL, OFS_CONV_HI,
      OFS_ADCTL0};
   localparam logic [7:0]     GEN_MASK [GEN_N] = '{MASK_ALL, MASK_ALL,
      MASK_ALL, MASK_HOLD, MASK_PIRQ2, MASK_T1CTL, MASK_ALL, MASK_T2CTL,
      MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL, MASK_ALL};
   // bit i set: entry i is decoded in every bank
   localparam logic [14:0]    GEN_MIRROR  = 15'h0009;
   // bit i set: entry i keeps its value over a pin or watchdog reset
   localparam logic [14:0]    GEN_KEEP    = 15'h2d07;
endpackage
`default_nettype wire

// ===== design/cbk_byte_reg.sv
`timescale 1ns/1ps
`default_nettype none
module cbk_byte_reg
   import cbk_pkg::*;
#(
   parameter logic [7:0] MASK = 8'hff,
   parameter logic [7:0] RST  = 8'h00,
   parameter bit         KEEP = 1'b0
)(
   // clock and resets
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       warm_rst_i,
   // write side
   input  wire logic       we_i,
   input  wire logic [7:0] wdata_i,
   // stored value
   output logic [7:0]      q_o
);
   // ==========================================================
   // storage
   logic [7:0] q_q;

   // unimplemented bits never take a one, so they read as zero
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         q_q <= RST & MASK;
      else if (warm_rst_i && !KEEP)
         q_q <= RST & MASK;
      else if (we_i)
         q_q <= wdata_i & MASK;
   end

   assign q_o = q_q;
endmodule // cbk_byte_reg
`default_nettype wire

// ===== design/cbk_timer16.sv
`timescale 1ns/1ps
`default_nettype none
module cbk_timer16
   import cbk_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // counting
   input  wire logic        tick_i,
   input  wire logic        run_i,
   // byte writes
   input  wire logic        wr_lo_i,
   input  wire logic        wr_hi_i,
   input  wire logic [7:0]  wdata_i,
   // state
   output logic [15:0]      count_o,
   output logic             ovf_o
);
   // ==========================================================
   // counter
   logic [15:0] count_q;
   logic        ovf_q;

   // a byte write beats a tick in the same cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         count_q <= RST_T1;
      else if (wr_lo_i)
         count_q[7:0] <= wdata_i;
      else if (wr_hi_i)
         count_q[15:8] <= wdata_i;
      else if (run_i && tick_i)
         count_q <= count_q + 16'h0001;
   end

   // one-cycle pulse on wrap from all ones
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         ovf_q <= 1'b0;
      else
         ovf_q <= run_i && tick_i && !wr_lo_i && !wr_hi_i
                  && (count_q == T1_MAX);
   end

   assign count_o = count_q;
   assign ovf_o   = ovf_q;
endmodule // cbk_timer16
`default_nettype wire

// ===== design/cbk_sfr_bank.sv
// Operation
// - holding register low five bits become PC bits 12:8 on counter load
// - no address reads or writes the upper program counter byte directly
// - indirect port, low pc, status, pointer, holding, interrupt control in all banks
// - unimplemented addresses and bits read zero, writes ignored
// - timer 1 counter is two byte registers, low then high
// - power-up reset loads reset values; pin and watchdog reset separate
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cbk_sfr_bank
   import cbk_pkg::*;
(
   // clock and resets
   input  wire logic              sys_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              warm_rst_i,
   input  wire logic              warm_by_wdt_i,
   // register port
   input  wire logic [6:0]        addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_en_i,
   input  wire logic              rd_en_i,
   output logic [7:0]             rdata_o,
   // program counter control
   input  wire logic              pc_step_i,
   input  wire logic              pc_jump_i,
   input  wire logic [JUMP_W-1:0] pc_target_i,
   output logic [PC_W-1:0]        pc_o,
   // core flag updates
   input  wire logic [2:0]        flag_we_i,
   input  wire logic [2:0]        flag_i,
   input  wire logic              sleep_i,
   input  wire logic              clrwdt_i,
   output logic [7:0]             status_o,
   // peripheral events
   input  wire logic              t0_tick_i,
   input  wire logic              t1_tick_i,
   input  wire logic [7:0]        pirq1_set_i,
   output logic [7:0]             irq_ctrl_o,
   output logic [7:0]             pirq1_o,
   // port pins
   input  wire logic [7:0]        pio_a_pins_i,
   input  wire logic [7:0]        pio_b_pins_i,
   output logic [7:0]             pio_a_o,
   output logic [7:0]             pio_b_o
);
   // ==========================================================
   // declarations
   logic [7:0]        rdata_q;
   logic [7:0]        rd_d;
   logic [PC_W-1:0]   pc_q;
   logic [7:0]        status_q;
   logic [7:0]        intctl_q;
   logic [7:0]        pirq1_q;
   logic [7:0]        t0cnt_q;
   logic [7:0]        gpr_mem [GPR_DEPTH];
   logic [7:0]        gen_q  [GEN_N];
   logic [7:0]        gen_rd [GEN_N];
   logic [GEN_N-1:0]  gen_sel;
   logic [15:0]       t1_count;
   logic              t1_ovf;
   logic [8:0]        eff_addr;
   logic [6:0]        eff_ofs;
   logic              eff_bank0;
   logic              ind_hit;
   logic              gpr_hit;
   logic [6:0]        gpr_idx;
   logic              wr_pc_lo;
   logic              wr_status;
   logic              wr_intctl;
   logic              wr_pirq1;
   logic              wr_t0cnt;
   logic              wr_t1lo;
   logic              wr_t1hi;
   logic              t0_wrap;

   // ==========================================================
   // address decode
   // indirect port resolves through the pointer; irp picks the bank pair
   assign ind_hit   = (addr_i == OFS_IND);
   assign eff_addr  = ind_hit ? {status_q[ST_IRP], gen_q[GI_PTR]}
                              : {status_q[6:5], addr_i};
   assign eff_ofs   = eff_addr[6:0];
   assign eff_bank0 = (eff_addr[8:7] == 2'b00);

   // bank 0 general purpose bytes; the top sixteen are common to all banks
   assign gpr_hit = (eff_ofs >= OFS_GPR_LO)
                    && (eff_bank0 || (eff_ofs >= OFS_GPR_COM));
   assign gpr_idx = eff_ofs - OFS_GPR_LO;

   // core registers answer whatever the bank selection
   assign wr_pc_lo  = wr_en_i && (eff_ofs == OFS_PC_LO);
   assign wr_status = wr_en_i && (eff_ofs == OFS_STATUS);
   assign wr_intctl = wr_en_i && (eff_ofs == OFS_INTCTL);
   // peripheral registers only in bank 0
   assign wr_t0cnt  = wr_en_i && eff_bank0 && (eff_ofs == OFS_T0CNT);
   assign wr_pirq1  = wr_en_i && eff_bank0 && (eff_ofs == OFS_PIRQ1);
   assign wr_t1lo   = wr_en_i && eff_bank0 && (eff_ofs == OFS_T1LO);
   assign wr_t1hi   = wr_en_i && eff_bank0 && (eff_ofs == OFS_T1HI);
   assign t0_wrap   = t0_tick_i && !wr_t0cnt && (t0cnt_q == T0_MAX);

   // ==========================================================
   // plain storage registers
   genvar gi;
   generate
      for (gi = 0; gi < GEN_N; gi++)
      begin : g_reg
         // mirrored entries ignore the bank bits
         assign gen_sel[gi] = (eff_ofs == GEN_OFS[gi])
                              && (GEN_MIRROR[gi] || eff_bank0);
         // port reads show the pins, not the output latch
         assign gen_rd[gi]  = (gi == GI_PA) ? pio_a_pins_i
                            : (gi == GI_PB) ? pio_b_pins_i
                            : gen_q[gi];
         cbk_byte_reg #(
            .MASK (GEN_MASK[gi]),
            .RST  (RST_ZERO),
            .KEEP (GEN_KEEP[gi])
         ) u_reg (
            .sys_clk_i  (sys_clk_i),
            .rst_b_i    (rst_b_i),
            .warm_rst_i (warm_rst_i),
            .we_i       (wr_en_i && gen_sel[gi]),
            .wdata_i    (wdata_i),
            .q_o        (gen_q[gi])
         );
      end
   endgenerate

   // ==========================================================
   // timer 1, split over two byte addresses
   cbk_timer16 u_t1 (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .tick_i    (t1_tick_i),
      .run_i     (gen_q[GI_T1CTL][T1CTL_ON]),
      .wr_lo_i   (wr_t1lo),
      .wr_hi_i   (wr_t1hi),
      .wdata_i   (wdata_i),
      .count_o   (t1_count),
      .ovf_o     (t1_ovf)
   );

   // ==========================================================
   // program counter
   // only the low byte has an address; the top bits come from holding
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i || warm_rst_i)
         pc_q <= RST_PC;
      else if (wr_pc_lo)
         pc_q <= {gen_q[GI_HOLD][HOLD_W-1:0], wdata_i};
      else if (pc_jump_i)
         pc_q <= {gen_q[GI_HOLD][HOLD_W-1:HOLD_W-2], pc_target_i};
      else if (pc_step_i)
         pc_q <= pc_q + 13'h0001;
   end

   // ==========================================================
   // core status flags
   // time-out and power-down are read only to software
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         status_q <= RST_STATUS;
      else if (warm_rst_i)
      begin
         // not a power-up: flags kept except time-out on a watchdog reset, bank select back to bank 0
         status_q[7:5] <= RST_STATUS[7:5];
         if (warm_by_wdt_i)
            status_q[ST_TO] <= 1'b0;
      end
      else
      begin
         if (wr_status)
            status_q <= (wdata_i & MASK_ST_SW)
                        | (status_q & ~MASK_ST_SW);
         if (sleep_i)
            status_q[ST_PD] <= 1'b0;
         if (clrwdt_i || sleep_i)
            status_q[ST_TO] <= 1'b1;
         if (clrwdt_i)
            status_q[ST_PD] <= 1'b1;
         // alu results win over a software write to the same flag
         for (int k = 0; k < 3; k++)
            if (flag_we_i[k])
               status_q[k] <= flag_i[k];
      end
   end

   // ==========================================================
   // timer 0 and interrupt control
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i || warm_rst_i)
         t0cnt_q <= RST_ZERO;
      else if (wr_t0cnt)
         t0cnt_q <= wdata_i;
      else if (t0_tick_i)
         t0cnt_q <= t0cnt_q + 8'h01;
   end

   // a wrap in the clearing cycle still sets the flag
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i || warm_rst_i)
         intctl_q <= RST_ZERO;
      else
      begin
         if (wr_intctl)
            intctl_q <= wdata_i;
         if (t0_wrap)
            intctl_q[IC_T0IF] <= 1'b1;
      end
   end

   // ==========================================================
   // peripheral flags 1: hardware sets win over a software clear
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i || warm_rst_i)
         pirq1_q <= RST_ZERO;
      else if (wr_pirq1)
         pirq1_q <= (wdata_i | pirq1_set_i | {7'h00, t1_ovf})
                    & MASK_PIRQ1;
      else
         pirq1_q <= (pirq1_q | pirq1_set_i | {7'h00, t1_ovf})
                    & MASK_PIRQ1;
   end

   // ==========================================================
   // general purpose data memory, no reset as it is plain ram
   always_ff @(posedge sys_clk_i)
   begin
      if (wr_en_i && gpr_hit)
         gpr_mem[gpr_idx] <= wdata_i;
   end

   // ==========================================================
   // read mux; anything not decoded falls through to zero
   always_comb
   begin
      rd_d = RST_ZERO;
      for (int i = 0; i < GEN_N; i++)
         if (gen_sel[i])
            rd_d = gen_rd[i];
      if (gpr_hit)
         rd_d = gpr_mem[gpr_idx];
      case (eff_ofs)
         OFS_PC_LO:  rd_d = pc_q[7:0];
         OFS_STATUS: rd_d = status_q;
         OFS_INTCTL: rd_d = intctl_q;
         OFS_T0CNT:  if (eff_bank0) rd_d = t0cnt_q;
         OFS_PIRQ1:  if (eff_bank0) rd_d = pirq1_q;
         OFS_T1LO:   if (eff_bank0) rd_d = t1_count[7:0];
         OFS_T1HI:   if (eff_bank0) rd_d = t1_count[15:8];
         default:    ;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         rdata_q <= RST_ZERO;
      else
         rdata_q <= rd_en_i ? rd_d : RST_ZERO;
   end

   // ==========================================================
   // outputs
   assign rdata_o    = rdata_q;
   assign pc_o       = pc_q;
   assign status_o   = status_q;
   assign irq_ctrl_o = intctl_q;
   assign pirq1_o    = pirq1_q;
   assign pio_a_o    = gen_q[GI_PA];
   assign pio_b_o    = gen_q[GI_PB];

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   pc_load_a: assert property (wr_en_i && addr_i == OFS_PC_LO && !warm_rst_i
      |=> pc_q == {$past(gen_q[GI_HOLD][4:0]), $past(wdata_i)})
      else $error("pc not loaded from holding and low byte");

   hold_read_a: assert property (rd_en_i && addr_i == OFS_HOLD
      |=> rdata_q == {3'b000, $past(gen_q[GI_HOLD][4:0])})
      else $error("holding address did not read the holding value");

   mirror_status_a: assert property (rd_en_i && addr_i == OFS_STATUS
      |=> rdata_q == $past(status_q))
      else $error("status not visible in current bank");

   hole_zero_a: assert property (rd_en_i && addr_i == 7'h07
      |=> rdata_q == 8'h00)
      else $error("unimplemented address read non-zero");

   hold_bits_a: assert property (gen_q[GI_HOLD][7:5] == 3'b000)
      else $error("unimplemented holding bits set");

   t1_high_a: assert property (rd_en_i && addr_i == OFS_T1HI
      && status_q[6:5] == 2'b00 |=> rdata_q == $past(t1_count[15:8]))
      else $error("timer 1 high byte read wrong");

   por_vals_a: assert property (disable iff (1'b0) !rst_b_i
      |=> status_q == RST_STATUS && pc_q == RST_PC
          && gen_q[GI_HOLD] == RST_ZERO)
      else $error("power-up reset values not applied");

   wdt_flag_a: assert property (warm_rst_i && warm_by_wdt_i
      |=> !status_q[ST_TO] && pc_q == RST_PC)
      else $error("watchdog reset did not clear time-out flag");

   ind_write_a: assert property (wr_en_i && ind_hit && !status_q[ST_IRP]
      && gen_q[GI_PTR] == 8'h21 |=> gpr_mem[1] == $past(wdata_i))
      else $error("indirect write missed the pointed byte");

   ind_self_a: assert property (rd_en_i && ind_hit
      && gen_q[GI_PTR] == 8'h00 |=> rdata_q == 8'h00)
      else $error("indirect access to itself read non-zero");

   // a low byte write outranks the jump, so it is left out here
   pc_jump_a: assert property (pc_jump_i && !wr_pc_lo && !warm_rst_i
      |=> pc_q == {$past(gen_q[GI_HOLD][4:3]), $past(pc_target_i)})
      else $error("pc jump did not take holding bits");

   pc_lo_read_a: assert property (rd_en_i && addr_i == OFS_PC_LO
      |=> rdata_q == $past(pc_q[7:0]))
      else $error("low pc byte read wrong");

   bank_hole_a: assert property (rd_en_i && addr_i == OFS_SERBUF
      && status_q[6:5] != 2'b00 |=> rdata_q == 8'h00)
      else $error("bank 0 register visible in another bank");

   rd_idle_a: assert property (!rd_en_i |=> rdata_q == 8'h00)
      else $error("read data stood without a strobe");

   t1_low_a: assert property (rd_en_i && addr_i == OFS_T1LO
      && status_q[6:5] == 2'b00 |=> rdata_q == $past(t1_count[7:0]))
      else $error("timer 1 low byte read wrong");

   warm_keep_a: assert property (warm_rst_i && !wr_en_i |=>
      gen_q[GI_PTR] == $past(gen_q[GI_PTR]) && intctl_q == 8'h00)
      else $error("warm reset lost pointer or kept control");
endmodule // cbk_sfr_bank
`default_nettype wire

// ===== design/cbk_unused_placeholder_none.sv
`default_nettype none
`default_nettype wire

// ===== testbench/cbk_sfr_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cbk_sfr_bank_tb
   import cbk_pkg::*;
;
   // ==========================================================
   // stimulus and observed signals
   logic                sys_clk_i;
   logic                rst_b_i;
   logic                warm_rst_i;
   logic                warm_by_wdt_i;
   logic [6:0]          addr_i;
   logic [7:0]          wdata_i;
   logic                wr_en_i;
   logic                rd_en_i;
   logic [7:0]          rdata_o;
   logic                pc_step_i;
   logic                pc_jump_i;
   logic [JUMP_W-1:0]   pc_target_i;
   logic [PC_W-1:0]     pc_o;
   logic [2:0]          flag_we_i;
   logic [2:0]          flag_i;
   logic                sleep_i;
   logic                clrwdt_i;
   logic [7:0]          status_o;
   logic                t0_tick_i;
   logic                t1_tick_i;
   logic [7:0]          pirq1_set_i;
   logic [7:0]          irq_ctrl_o;
   logic [7:0]          pirq1_o;
   logic [7:0]          pio_a_pins_i;
   logic [7:0]          pio_b_pins_i;
   logic [7:0]          pio_a_o;
   logic [7:0]          pio_b_o;
   // bookkeeping
   int                  bad_count = 0;
   int                  total_checks = 0;
   int                  seed = 40564;
   logic [7:0]          exp_q [$];
   logic                rd_seen = 1'b0;
   logic [7:0]          r0;
   logic [7:0]          r1;
   logic [7:0]          r2;

   cbk_sfr_bank u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .warm_rst_i(warm_rst_i), .warm_by_wdt_i(warm_by_wdt_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_en_i(wr_en_i),
      .rd_en_i(rd_en_i), .rdata_o(rdata_o), .pc_step_i(pc_step_i),
      .pc_jump_i(pc_jump_i), .pc_target_i(pc_target_i), .pc_o(pc_o),
      .flag_we_i(flag_we_i), .flag_i(flag_i), .sleep_i(sleep_i),
      .clrwdt_i(clrwdt_i), .status_o(status_o), .t0_tick_i(t0_tick_i),
      .t1_tick_i(t1_tick_i), .pirq1_set_i(pirq1_set_i),
      .irq_ctrl_o(irq_ctrl_o), .pirq1_o(pirq1_o),
      .pio_a_pins_i(pio_a_pins_i), .pio_b_pins_i(pio_b_pins_i),
      .pio_a_o(pio_a_o), .pio_b_o(pio_b_o));

   // ==========================================================
   // clock and helpers
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic check(input string what, input logic [15:0] exp,
                        input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one-cycle register write, strobe dropped at the taking edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_en_i <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_en_i <= 1'b0;
   endtask

   // read request; the expected byte is queued for the monitor
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge sys_clk_i);
      rd_en_i <= 1'b1;
      addr_i  <= a;
      @(posedge sys_clk_i);
      rd_en_i <= 1'b0;
   endtask

   // one-cycle pulse on {warm reset, t1 tick, t0 tick, pc step}
   task automatic strobe(input logic [3:0] m);
      @(posedge sys_clk_i);
      {warm_rst_i, t1_tick_i, t0_tick_i, pc_step_i} <= m;
      @(posedge sys_clk_i);
      {warm_rst_i, t1_tick_i, t0_tick_i, pc_step_i} <= 4'h0;
   endtask

   // pc settles at the taking edge, so look half a cycle later
   task automatic chk_pc(input logic [PC_W-1:0] e);
      @(negedge sys_clk_i);
      check("pc", {3'h0, e}, {3'h0, pc_o});
   endtask

   // ==========================================================
   // monitor: read data stands only the cycle after the strobe
   always @(posedge sys_clk_i)
   begin
      if (rd_seen && exp_q.size() > 0)
         check("read data", {8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
      rd_seen <= rd_en_i;
   end

   // hang guard, well beyond the some 120 cycles of the run
   initial
   begin
      #50000;
      bad_count++;
      $display("[FAIL] run end expected done seen timeout");
      tally_and_finish();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      {rst_b_i, warm_rst_i, warm_by_wdt_i, wr_en_i, rd_en_i} = 5'h0;
      {pc_step_i, pc_jump_i, t0_tick_i, t1_tick_i, sleep_i} = 5'h0;
      {addr_i, wdata_i, pc_target_i, clrwdt_i} = 27'h0;
      {flag_we_i, flag_i, pirq1_set_i} = 14'h0;
      pio_a_pins_i = 8'($random(seed));
      pio_b_pins_i = 8'($random(seed));
      repeat (4) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      // power-up values and pin readback
      rd(OFS_STATUS, RST_STATUS);
      rd(OFS_HOLD, RST_ZERO);
      rd(OFS_PIRQ1, RST_ZERO);
      rd(OFS_PIO_A, pio_a_pins_i);
      rd(OFS_PIO_B, pio_b_pins_i);
      // empty places and unused bits read zero, writes dropped
      rd(7'h07, 8'h00);
      wr(7'h18, 8'hff);
      rd(7'h18, 8'h00);
      wr(OFS_HOLD, 8'hff);
      rd(OFS_HOLD, MASK_HOLD);
      wr(OFS_PIRQ2, 8'hff);
      rd(OFS_PIRQ2, MASK_PIRQ2);
      // counter load from the holding register, step and jump
      wr(OFS_HOLD, 8'h03);
      wr(OFS_PC_LO, 8'h10);
      chk_pc(13'h0310);
      strobe(4'b0001);
      chk_pc(13'h0311);
      wr(OFS_HOLD, 8'h18);
      @(posedge sys_clk_i);
      pc_jump_i   <= 1'b1;
      pc_target_i <= 11'h123;
      @(posedge sys_clk_i);
      pc_jump_i   <= 1'b0;
      chk_pc(13'h1923);
      rd(OFS_PC_LO, 8'h23);
      // split timer 1: byte access, stopped, then wrap
      r0 = 8'($random(seed));
      r1 = 8'($random(seed));
      wr(OFS_T1LO, r0);
      wr(OFS_T1HI, r1);
      strobe(4'b0100);
      rd(OFS_T1LO, r0);
      rd(OFS_T1HI, r1);
      wr(OFS_T1CTL, 8'h01);
      wr(OFS_T1LO, 8'hff);
      wr(OFS_T1HI, 8'hff);
      strobe(4'b0100);
      rd(OFS_T1LO, 8'h00);
      rd(OFS_T1HI, 8'h00);
      rd(OFS_PIRQ1, 8'h01);
      wr(OFS_T0CNT, 8'hff);
      strobe(4'b0010);
      rd(OFS_T0CNT, 8'h00);
      rd(OFS_INTCTL, 8'h04);
      // indirect port acts on the pointed location
      r2 = 8'($random(seed));
      wr(OFS_PTR, 8'h21);
      wr(OFS_IND, r2);
      rd(7'h21, r2);
      rd(OFS_IND, r2);
      wr(OFS_PTR, 8'h00);
      rd(OFS_IND, 8'h00);
      // output latches, then core flag and event inputs
      wr(OFS_PIO_A, r1);
      wr(OFS_PIO_B, r2);
      @(negedge sys_clk_i);
      check("latch a", {8'h00, r1}, {8'h00, pio_a_o});
      check("latch b", {8'h00, r2}, {8'h00, pio_b_o});
      @(posedge sys_clk_i);
      sleep_i     <= 1'b1;
      flag_we_i   <= 3'h7;
      flag_i      <= 3'h5;
      pirq1_set_i <= 8'hff;
      @(posedge sys_clk_i);
      sleep_i     <= 1'b0;
      flag_we_i   <= 3'h0;
      pirq1_set_i <= 8'h00;
      @(negedge sys_clk_i);
      check("status", 16'h0015, {8'h00, status_o});
      check("flags 1", {8'h00, MASK_PIRQ1}, {8'h00, pirq1_o});
      check("int ctl", 16'h0004, {8'h00, irq_ctrl_o});
      @(posedge sys_clk_i);
      clrwdt_i <= 1'b1;
      @(posedge sys_clk_i);
      clrwdt_i <= 1'b0;
      @(negedge sys_clk_i);
      check("status", 16'h001d, {8'h00, status_o});
      // bank 1: mirrored core registers only
      wr(OFS_SERBUF, r0);
      wr(OFS_STATUS, 8'h20);
      rd(OFS_STATUS, 8'h38);
      rd(OFS_HOLD, 8'h18);
      rd(OFS_INTCTL, 8'h04);
      rd(OFS_SERBUF, 8'h00);
      // watchdog-caused warm reset: a class of its own
      @(posedge sys_clk_i);
      warm_by_wdt_i <= 1'b1;
      strobe(4'b1000);
      chk_pc(13'h0000);
      rd(OFS_STATUS, 8'h08);
      rd(OFS_SERBUF, r0);
      rd(OFS_HOLD, 8'h00);
      rd(OFS_INTCTL, 8'h00);
      repeat (3) @(posedge sys_clk_i);
      check("pending reads", 16'h0, 16'(exp_q.size()));
      tally_and_finish();
   end
endmodule // cbk_sfr_bank_tb
`default_nettype wire
